/* inc/cpu_core_pkg.sv */
package cpu_core_pkg;

   // Architectural widths
   localparam int PC_WIDTH       = 23;
   localparam int INSTR_WIDTH    = 24;
   localparam int DATA_WIDTH     = 16;
   localparam int REG_COUNT      = 16;
   localparam int REG_IDX_WIDTH  = 4;
   localparam int MUL_WIDTH      = 17;
   localparam int DATA_ADDR_BITS = 16;
   localparam int PAGE_WIDTH     = 8;
   localparam int WINDOW_OFF_BITS = 15;
   localparam int DIV_CYCLES     = 19;
   localparam int DIV_STEPS      = 17;
   localparam int SHIFT_WIDTH    = 5;

   // Stack pointer is the last working register
   localparam logic [3:0] STACK_REG_IDX = 4'hF;

   // Data space regions (byte addresses)
   localparam logic [15:0] WINDOW_BASE   = 16'h8000;
   localparam logic [15:0] DMA_RAM_BASE  = 16'h4000;
   localparam logic [15:0] DMA_RAM_BYTES = 16'h0800;
   localparam logic [1:0]  PC_STEP       = 2'h2;

   // Register map on the AXI4-Lite slave
   localparam logic [7:0] ADDR_STATUS   = 8'h00;
   localparam logic [7:0] ADDR_CONTROL  = 8'h04;
   localparam logic [7:0] ADDR_PAGE     = 8'h08;
   localparam logic [7:0] ADDR_INTCTL   = 8'h0C;
   localparam logic [7:0] ADDR_PC       = 8'h10;
   localparam logic [7:0] ADDR_LOOP     = 8'h14;
   localparam logic [7:0] ADDR_WREG     = 8'h40;
   localparam logic [7:0] ADDR_WREG_END = 8'h7C;

   // Status word fields
   localparam int SR_HALF_CARRY = 8;
   localparam int SR_PRIO_HI    = 7;
   localparam int SR_PRIO_LO    = 5;
   localparam int SR_LOOP       = 4;
   localparam int SR_NEG        = 3;
   localparam int SR_EXCESS     = 2;
   localparam int SR_ZERO       = 1;
   localparam int SR_CARRY      = 0;
   localparam logic [15:0] SR_RESET = 16'h0000;

   // Control word fields
   localparam int CC_PRIO_UPPER = 3;
   localparam int CC_WINDOW_EN  = 2;
   localparam logic [15:0] CC_RESET    = 16'h0020;
   localparam logic [15:0] CC_IMPL     = 16'h00F0;
   localparam int          IC_NEST_DIS = 15;
   localparam logic [2:0]  PRIO_USER_OFF = 3'h7;

   localparam logic [1:0] RESP_OKAY   = 2'h0;
   localparam logic [1:0] RESP_SLVERR = 2'h2;

   // Core operations
   typedef enum logic [3:0] {
      OP_NOP, OP_ADD, OP_SUB, OP_AND, OP_OR, OP_XOR, OP_MUL, OP_SHIFT,
      OP_DIV, OP_REPEAT, OP_BRANCH, OP_CALL, OP_RETURN, OP_MOVD, OP_TABLE, OP_MOV
   } op_t;

   typedef enum logic [1:0] {EXEC, STALL} exec_state_t;

   typedef struct packed {
      logic        valid;
      op_t         op;
      logic        byte_mode;
      logic [1:0]  mul_sign;   // [1] a signed, [0] b signed
      logic [3:0]  dst;
      logic [3:0]  src_a;
      logic [3:0]  src_b;
      logic [15:0] literal;
   } instr_t;

   typedef struct packed {
      logic        valid;
      logic [7:0]  addr;
      logic [31:0] data;
      logic [3:0]  strb;
   } axi_hold_t;

endpackage : cpu_core_pkg

/* verilog/cpu_core_status_control.sv */
// Functional notes
// - Program counter is 23 bits, addressing 4M words of 24-bit program memory.
// - Fetches 24-bit instruction words with single-cycle prefetch.
// - One cycle per instruction except flow changes, double-word move, table ops.
// - Loop-repeat runs without overhead and may be interrupted at any iteration.
// - Sixteen 16-bit working registers usable as data, address or offset.
// - Last working register serves as stack pointer for interrupts and calls.
// - Data space is linearly addressed as 32K words or 64 Kbytes.
// - With window on, upper 32 Kbytes map to program space via 8-bit page.
// - 2 Kbytes of DMA memory sit in data space, usable as plain RAM.
// - 17x17 single-cycle multiplier gives signed, unsigned and mixed products.
// - Division iterates in a loop-repeat for 19 cycles, interrupt-safe.
// - Shifter moves operand left or right up to 16 bits in one cycle.
// - Half-carry at bit 8: carry out of bit 3 (byte) or bit 7 (word).
// - Status bits 7..5 hold priority 0..7; 7 disables user interrupts.
// - Control bit 3 extends priority to 4 bits; set disables user interrupts.
// - Priority bits read-only while nesting-disable bit is set.
// - Loop-active flag at bit 4 is high during a loop-repeat.
// - Negative flag at bit 3 follows result sign.
// - Overflow flag at bit 2 marks signed overflow.
// - Zero flag at bit 1 set on zero result, cleared on non-zero.
// - Carry flag at bit 0 is carry out of MSB, inverted borrow for subtraction.
// - Control bit 2 enables the program-space window.
//
// Decided for this implementation: the AXI4-Lite register port and the register addresses.
`timescale 1ns/1ps
`default_nettype none
module cpu_core_status_control
   import cpu_core_pkg::*;
(
   input  wire logic                    aclk,
   input  wire logic                    aresetn,
   // Instruction fetch and interrupts
   output logic [PC_WIDTH-1:0]          pc,
   input  wire logic [INSTR_WIDTH-1:0]  fetch_word,
   input  wire instr_t                  instr,
   input  wire logic                    irq_request,
   input  wire logic [3:0]              irq_level,
   output logic                         irq_taken,
   output logic                         user_irq_disabled,
   // Data address path
   input  wire logic [15:0]             data_addr,
   output logic                         addr_is_window,
   output logic                         addr_is_dma,
   output logic [INSTR_WIDTH-1:0]       program_addr,
   // AXI4-Lite slave
   input  wire logic [7:0]              s_axi_awaddr,
   input  wire logic                    s_axi_awvalid,
   output logic                         s_axi_awready,
   input  wire logic [31:0]             s_axi_wdata,
   input  wire logic [3:0]              s_axi_wstrb,
   input  wire logic                    s_axi_wvalid,
   output logic                         s_axi_wready,
   output logic [1:0]                   s_axi_bresp,
   output logic                         s_axi_bvalid,
   input  wire logic                    s_axi_bready,
   input  wire logic [7:0]              s_axi_araddr,
   input  wire logic                    s_axi_arvalid,
   output logic                         s_axi_arready,
   output logic [31:0]                  s_axi_rdata,
   output logic [1:0]                   s_axi_rresp,
   output logic                         s_axi_rvalid,
   input  wire logic                    s_axi_rready
);

   typedef struct packed {
      logic [PC_WIDTH-1:0]    pc;
      logic [INSTR_WIDTH-1:0] prefetch;
      exec_state_t            state;
      logic [1:0]             stall_cnt;
      logic [15:0]            status;
      logic [15:0]            control;
      logic [7:0]             page;
      logic [15:0]            intctl;
      logic [15:0]            loop_count;
      logic [4:0]             div_cnt;
      logic [REG_COUNT-1:0][15:0] wreg;
      logic                   irq_taken;
      axi_hold_t              aw;
      logic                   bvalid;
      logic [1:0]             bresp;
      logic                   rvalid;
      logic [1:0]             rresp;
      logic [31:0]            rdata;
   } state_t;

   state_t st;
   state_t next_st;

   // Result flags of an add or subtract, byte or word wide
   function automatic logic [4:0] arith_flags(input logic [15:0] a, input logic [15:0] b,
                                              input logic sub, input logic bw);
      logic [16:0] sum;
      logic [8:0]  nib;
      logic [15:0] bb;
      logic        c;
      logic        hc;
      logic        n;
      logic        v;
      logic        z;
      bb  = sub ? ~b : b;
      sum = {1'b0, a} + {1'b0, bb} + {16'h0000, sub};
      nib = {1'b0, a[7:0]} + {1'b0, bb[7:0]} + {8'h00, sub};
      if (bw) begin
         c  = nib[8];
         hc = (a[3:0] + bb[3:0] + {3'h0, sub}) > 5'h0F;
         n  = nib[7];
         v  = (a[7] == bb[7]) && (nib[7] != a[7]);
         z  = (nib[7:0] == 8'h00);
      end else begin
         c  = sum[16];
         hc = nib[8];
         n  = sum[15];
         v  = (a[15] == bb[15]) && (sum[15] != a[15]);
         z  = (sum[15:0] == 16'h0000);
      end
      arith_flags = {hc, n, v, z, c};
   endfunction : arith_flags

   // Flow-change, double-word move and table ops take an extra cycle
   function automatic logic two_cycle(input op_t op);
      two_cycle = (op == OP_BRANCH) || (op == OP_CALL) || (op == OP_RETURN) ||
                  (op == OP_MOVD) || (op == OP_TABLE);
   endfunction : two_cycle

   logic [15:0] opa;
   logic [15:0] opb;
   logic [4:0]  flg;
   logic [33:0] product;
   logic [15:0] shifted;
   logic [16:0] div_rem;
   logic [3:0]  prio4;
   logic        axi_wr_go;
   logic        axi_rd_go;
   logic [15:0] wr_val;
   logic [15:0] rd_val;

   assign opa     = st.wreg[instr.src_a];
   assign opb     = st.wreg[instr.src_b];
   assign flg     = arith_flags(opa, opb, instr.op == OP_SUB, instr.byte_mode);
   // Sign extend each side to 17 bits, so mixed sign needs no extra logic
   assign product = $signed({instr.mul_sign[1] & opa[15], opa}) *
                    $signed({instr.mul_sign[0] & opb[15], opb});
   // Positive count shifts right, negative left, magnitude up to 16
   assign shifted = instr.literal[15] ? (opa << (5'h00 - instr.literal[SHIFT_WIDTH-1:0]))
                                      : (opa >> instr.literal[SHIFT_WIDTH-1:0]);
   assign div_rem = {st.wreg[1], st.wreg[0][15]} - {1'b0, opb};
   assign prio4   = {st.control[CC_PRIO_UPPER], st.status[SR_PRIO_HI:SR_PRIO_LO]};

   // Window and DMA region decode on the data address
   assign addr_is_window = st.control[CC_WINDOW_EN] && data_addr[15];
   assign addr_is_dma    = (data_addr >= DMA_RAM_BASE) &&
                           (data_addr < DMA_RAM_BASE + DMA_RAM_BYTES);
   assign program_addr   = {1'b0, st.page, data_addr[WINDOW_OFF_BITS-1:0]};

   assign pc                = st.pc;
   assign irq_taken         = st.irq_taken;
   assign user_irq_disabled = prio4[3] || (prio4[2:0] == PRIO_USER_OFF);

   // AXI handshakes: one write and one read outstanding
   assign s_axi_awready = !st.aw.valid && !st.bvalid;
   // Data is only taken together with an address, so never accept it alone
   assign s_axi_wready  = !st.bvalid && (st.aw.valid || s_axi_awvalid);
   assign s_axi_bvalid  = st.bvalid;
   assign s_axi_bresp   = st.bresp;
   assign s_axi_arready = !st.rvalid;
   assign s_axi_rvalid  = st.rvalid;
   assign s_axi_rresp   = st.rresp;
   assign s_axi_rdata   = st.rdata;
   assign axi_wr_go     = (st.aw.valid || s_axi_awvalid) && s_axi_wvalid && !st.bvalid;
   assign axi_rd_go     = s_axi_arvalid && !st.rvalid;

   // Merge byte strobes into low 16 bits
   function automatic logic [15:0] merge(input logic [15:0] old, input logic [31:0] d,
                                         input logic [3:0] s);
      merge = {s[1] ? d[15:8] : old[15:8], s[0] ? d[7:0] : old[7:0]};
   endfunction : merge

   always_comb begin
      logic [7:0] wa;
      logic       excl;
      wa      = st.aw.valid ? st.aw.addr : s_axi_awaddr;
      excl    = 1'b0;
      next_st = st;
      next_st.irq_taken = 1'b0;
      wr_val  = 16'h0000;
      rd_val  = 16'h0000;

      // Execute: prefetch next word while current instruction runs
      case (st.state)
         EXEC: begin
            if (irq_request && !user_irq_disabled && irq_level > prio4) begin
               // Loop and divider state stay intact in registers across the interrupt
               next_st.wreg[STACK_REG_IDX] = st.wreg[STACK_REG_IDX] + 16'h0002;
               next_st.irq_taken = 1'b1;
               next_st.state     = STALL;
            end else if (instr.valid) begin
               next_st.prefetch = fetch_word;
               if (st.loop_count == 16'h0000)
                  next_st.pc = st.pc + {{(PC_WIDTH-2){1'b0}}, PC_STEP};
               else
                  next_st.loop_count = st.loop_count - 16'h0001;
               case (instr.op)
                  OP_ADD, OP_SUB: begin
                     next_st.wreg[instr.dst] = instr.op == OP_SUB ? opa - opb : opa + opb;
                     next_st.status[SR_HALF_CARRY] = flg[4];
                     next_st.status[SR_NEG:SR_CARRY] = flg[3:0];
                  end
                  OP_AND: next_st.wreg[instr.dst] = opa & opb;
                  OP_OR:  next_st.wreg[instr.dst] = opa | opb;
                  OP_XOR: next_st.wreg[instr.dst] = opa ^ opb;
                  OP_MOV: next_st.wreg[instr.dst] = opa;
                  OP_MUL: begin
                     next_st.wreg[instr.dst]        = product[15:0];
                     next_st.wreg[instr.dst + 4'h1] = product[31:16];
                  end
                  OP_SHIFT: next_st.wreg[instr.dst] = shifted;
                  OP_REPEAT: next_st.loop_count = instr.literal;
                  OP_DIV: begin
                     // One restoring step per cycle for the first 17 of 19 cycles, quotient into W0, remainder W1
                     if (st.div_cnt < DIV_STEPS) begin
                        next_st.wreg[1] = div_rem[16] ? {st.wreg[1][14:0], st.wreg[0][15]}
                                                      : div_rem[15:0];
                        next_st.wreg[0] = {st.wreg[0][14:0], !div_rem[16]};
                     end
                     next_st.div_cnt = (st.div_cnt == 5'(DIV_CYCLES - 1)) ? 5'h00
                                                                         : st.div_cnt + 5'h01;
                  end
                  OP_CALL: next_st.wreg[STACK_REG_IDX] = st.wreg[STACK_REG_IDX] + 16'h0004;
                  OP_RETURN: next_st.wreg[STACK_REG_IDX] = st.wreg[STACK_REG_IDX] - 16'h0004;
                  default: ;
               endcase
               if (instr.op == OP_BRANCH || instr.op == OP_CALL)
                  next_st.pc = {instr.literal, 7'h00};
               if (two_cycle(instr.op)) begin
                  next_st.state     = STALL;
                  next_st.stall_cnt = 2'h1;
               end
            end
         end
         STALL: begin
            next_st.stall_cnt = st.stall_cnt - 2'h1;
            if (st.stall_cnt <= 2'h1)
               next_st.state = EXEC;
         end
         default: next_st.state = EXEC;
      endcase
      next_st.status[SR_LOOP] = (next_st.loop_count != 16'h0000);

      // Register write; software takes priority over core for the same word
      if (axi_wr_go) begin
         next_st.aw.valid = 1'b0;
         next_st.bvalid   = 1'b1;
         next_st.bresp    = RESP_OKAY;
         case (wa)
            ADDR_STATUS: begin
               wr_val = merge(st.status, s_axi_wdata, s_axi_wstrb);
               // Loop flag and bits 15..9 stay hardware owned
               next_st.status[SR_HALF_CARRY] = wr_val[SR_HALF_CARRY];
               next_st.status[SR_NEG:SR_CARRY] = wr_val[SR_NEG:SR_CARRY];
               if (!st.intctl[IC_NEST_DIS])
                  next_st.status[SR_PRIO_HI:SR_PRIO_LO] = wr_val[SR_PRIO_HI:SR_PRIO_LO];
            end
            ADDR_CONTROL: begin
               wr_val = merge(st.control, s_axi_wdata, s_axi_wstrb);
               // Priority upper bit is clear only
               next_st.control = (wr_val & CC_IMPL) | (st.control & ~CC_IMPL);
               next_st.control[CC_WINDOW_EN]  = wr_val[CC_WINDOW_EN];
               next_st.control[CC_PRIO_UPPER] = st.control[CC_PRIO_UPPER] & wr_val[CC_PRIO_UPPER];
            end
            ADDR_PAGE:   next_st.page   = s_axi_wstrb[0] ? s_axi_wdata[7:0] : st.page;
            ADDR_INTCTL: next_st.intctl = merge(st.intctl, s_axi_wdata, s_axi_wstrb);
            default: begin
               if (wa >= ADDR_WREG && wa <= ADDR_WREG_END)
                  next_st.wreg[wa[5:2]] = merge(st.wreg[wa[5:2]], s_axi_wdata, s_axi_wstrb);
               else
                  excl = 1'b1;
            end
         endcase
         if (excl)
            next_st.bresp = RESP_SLVERR;
      end else if (s_axi_awvalid && !st.aw.valid && !st.bvalid) begin
         next_st.aw.valid = 1'b1;
         next_st.aw.addr  = s_axi_awaddr;
      end
      if (st.bvalid && s_axi_bready)
         next_st.bvalid = 1'b0;

      // Register read
      if (axi_rd_go) begin
         next_st.rvalid = 1'b1;
         next_st.rresp  = RESP_OKAY;
         case (s_axi_araddr)
            ADDR_STATUS:  rd_val = st.status;
            ADDR_CONTROL: rd_val = st.control;
            ADDR_PAGE:    rd_val = {8'h00, st.page};
            ADDR_INTCTL:  rd_val = st.intctl;
            ADDR_PC:      rd_val = st.pc[15:0];
            ADDR_LOOP:    rd_val = st.loop_count;
            default: begin
               if (s_axi_araddr >= ADDR_WREG && s_axi_araddr <= ADDR_WREG_END)
                  rd_val = st.wreg[s_axi_araddr[5:2]];
               else
                  next_st.rresp = RESP_SLVERR;
            end
         endcase
         next_st.rdata = (s_axi_araddr == ADDR_PC) ? {9'h000, st.pc} : {16'h0000, rd_val};
      end else if (st.rvalid && s_axi_rready) begin
         next_st.rvalid = 1'b0;
      end

      if (!aresetn) begin
         next_st = '0;
         next_st.status  = SR_RESET;
         next_st.control = CC_RESET;
         next_st.state   = EXEC;
      end
   end

   // Single state register, reset folded into next_st
   always_ff @(posedge aclk) begin
      st <= next_st;
   end

endmodule : cpu_core_status_control
`default_nettype wire

/* test/cpu_core_status_control_assertions.sv */
`timescale 1ns/1ps
`default_nettype none
module cpu_core_status_control_assertions
   import cpu_core_pkg::*;
(
   input wire logic                   aclk,
   input wire logic                   aresetn,
   input wire logic [15:0]            data_addr,
   input wire logic                   addr_is_window,
   input wire logic                   addr_is_dma,
   input wire logic [INSTR_WIDTH-1:0] program_addr,
   input wire logic                   s_axi_awvalid,
   input wire logic                   s_axi_awready,
   input wire logic                   s_axi_wvalid,
   input wire logic                   s_axi_wready,
   input wire logic                   s_axi_bvalid,
   input wire logic                   s_axi_bready,
   input wire logic [1:0]             s_axi_bresp,
   input wire logic                   s_axi_arvalid,
   input wire logic                   s_axi_arready,
   input wire logic [7:0]             s_axi_araddr,
   input wire logic                   s_axi_rvalid,
   input wire logic                   s_axi_rready,
   input wire logic [31:0]            s_axi_rdata,
   input wire logic [1:0]             s_axi_rresp
);
   // Single domain, so clock and reset are given once
   default clocking cb @(posedge aclk);
   endclocking
   default disable iff (!aresetn);

   // Answers stand until the master takes them
   property p_b_hold;
      s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp);
   endproperty
   a_b_hold: assert property (p_b_hold) else $error("write answer dropped early");
   property p_r_hold;
      s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata);
   endproperty
   a_r_hold: assert property (p_r_hold) else $error("read answer dropped early");
   // Write answer one cycle after the take; no new data while it stands
   property p_b_answer;
      s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready |=> s_axi_bvalid && !s_axi_wready;
   endproperty
   a_b_answer: assert property (p_b_answer) else $error("write answer late");
   // Hole in the map answers with an error and zero data
   property p_unmapped;
      s_axi_arvalid && s_axi_arready && s_axi_araddr == 8'h20 |=> s_axi_rvalid ##0 s_axi_rresp == RESP_SLVERR && s_axi_rdata == 32'h0;
   endproperty
   a_unmapped: assert property (p_unmapped) else $error("unmapped read not refused");
   property p_status_zero;
      s_axi_arvalid && s_axi_arready && s_axi_araddr == ADDR_STATUS |=> s_axi_rdata[31:9] == 23'h0;
   endproperty
   a_status_zero: assert property (p_status_zero) else $error("status spare bits set");
   property p_control_zero;
      s_axi_arvalid && s_axi_arready && s_axi_araddr == ADDR_CONTROL |=> s_axi_rdata[31:8] == 24'h0 && s_axi_rdata[1:0] == 2'h0;
   endproperty
   a_control_zero: assert property (p_control_zero) else $error("control spare bits set");
   property p_dma;
      addr_is_dma == (data_addr >= DMA_RAM_BASE && data_addr < DMA_RAM_BASE + DMA_RAM_BYTES);
   endproperty
   a_dma: assert property (p_dma) else $error("dma region decode wrong");
   property p_window_map;
      addr_is_window |-> data_addr[15] && !program_addr[23] && program_addr[14:0] == data_addr[14:0];
   endproperty
   a_window_map: assert property (p_window_map) else $error("window mapping wrong");

   c_write: cover property (s_axi_bvalid && s_axi_bready);
   c_error: cover property (s_axi_rvalid && s_axi_rresp == RESP_SLVERR);
   c_window: cover property (addr_is_window);
endmodule : cpu_core_status_control_assertions

bind cpu_core_status_control cpu_core_status_control_assertions i_chk (
   .aclk, .aresetn, .data_addr, .addr_is_window, .addr_is_dma, .program_addr,
   .s_axi_awvalid, .s_axi_awready, .s_axi_wvalid, .s_axi_wready, .s_axi_bvalid,
   .s_axi_bready, .s_axi_bresp, .s_axi_arvalid, .s_axi_arready, .s_axi_araddr,
   .s_axi_rvalid, .s_axi_rready, .s_axi_rdata, .s_axi_rresp
);
`default_nettype wire

/* test/cpu_core_status_control_bench.sv */
`timescale 1ns/1ps
`default_nettype none
module cpu_core_status_control_bench
   import cpu_core_pkg::*;
;
   logic                   aclk, aresetn, irq_request, irq_taken, user_irq_disabled;
   logic                   addr_is_window, addr_is_dma;
   logic [PC_WIDTH-1:0]    pc;
   logic [INSTR_WIDTH-1:0] fetch_word, program_addr;
   instr_t                 instr;
   logic [3:0]             irq_level, s_axi_wstrb;
   logic [15:0]            data_addr, st, cc;
   logic [7:0]             s_axi_awaddr, s_axi_araddr;
   logic [31:0]            s_axi_wdata, s_axi_rdata, seed, wv;
   logic [1:0]             s_axi_bresp, s_axi_rresp;
   logic                   s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready;
   logic                   s_axi_bvalid, s_axi_bready, s_axi_arvalid, s_axi_arready;
   logic                   s_axi_rvalid, s_axi_rready, aw_p, w_p;
   logic [15:0]            wsave [REG_COUNT];
   logic [15:0]            corner [8] = '{16'h3FFF, 16'h4000, 16'h47FF, 16'h4800,
                                          16'h7FFF, 16'h8000, 16'hFFFF, 16'h0000};
   int                     fails = 0, n_compared = 0, cycles = 0;

   cpu_core_status_control i_dut (.*);

   initial begin
      aclk = 1'b0;
      forever #2 aclk = ~aclk;
   end
   // Hang guard, far above the few hundred cycles needed
   always @(posedge aclk) begin
      cycles <= cycles + 1;
      if (cycles == 20000) begin
         fails = fails + 1;
         print_verdict();
      end
   end

   task automatic print_verdict();
      $display("compared %0d mismatches %0d", n_compared, fails);
      if (fails == 0 && n_compared > 0)
         $display("RESULT: PASS");
      else
         $display("RESULT: FAIL");
      $finish;
   endtask : print_verdict

   task automatic chk_word(input string what, input logic [31:0] e, input logic [31:0] g);
      n_compared++;
      if (g !== e) begin
         fails++;
         $display("mismatch %s expected %h seen %h", what, e, g);
      end
   endtask : chk_word

   // Address and data offered together, ready for the answer from the start
   task automatic reg_wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] er);
      {aw_p, w_p} = 2'h3;
      s_axi_bready <= 1'b1;
      s_axi_awaddr <= a;
      s_axi_wdata <= d;
      s_axi_awvalid <= 1'b1;
      s_axi_wvalid <= 1'b1;
      while (aw_p || w_p) begin
         @(posedge aclk);
         if (s_axi_awready) aw_p = 1'b0;
         if (s_axi_wready) w_p = 1'b0;
         s_axi_awvalid <= aw_p;
         s_axi_wvalid <= w_p;
      end
      while (!s_axi_bvalid) @(posedge aclk);
      chk_word("write response", {30'h0, er}, {30'h0, s_axi_bresp});
      s_axi_bready <= 1'b0;
      @(posedge aclk);
   endtask : reg_wr

   task automatic reg_rd(input logic [7:0] a, input logic [31:0] e, input logic [1:0] er);
      s_axi_araddr <= a;
      s_axi_arvalid <= 1'b1;
      s_axi_rready <= 1'b1;
      @(posedge aclk);
      while (!s_axi_arready) @(posedge aclk);
      s_axi_arvalid <= 1'b0;
      @(posedge aclk);
      while (!s_axi_rvalid) @(posedge aclk);
      chk_word("read response", {30'h0, er}, {30'h0, s_axi_rresp});
      chk_word("read data", e, s_axi_rdata);
      s_axi_rready <= 1'b0;
      @(posedge aclk);
   endtask : reg_rd

   // Loop flag stays clear: no repeat is ever issued here
   function automatic logic [15:0] exp_status(input logic [15:0] w, o, input logic nest);
      return (w & 16'h010F) | ((nest ? o : w) & 16'h00E0);
   endfunction : exp_status
   // Upper priority bit can only be cleared by software
   function automatic logic [15:0] exp_control(input logic [15:0] w, o);
      return (w & 16'h00F4) | (o & w & 16'h0008);
   endfunction : exp_control

   initial begin
      seed = 32'h5F56D55C;
      {aresetn, irq_request, irq_level, s_axi_bready, s_axi_rready} = '0;
      {s_axi_awvalid, s_axi_wvalid, s_axi_arvalid, s_axi_awaddr, s_axi_araddr} = '0;
      {s_axi_wdata, fetch_word, data_addr, instr} = '0;
      s_axi_wstrb = 4'hF;
      repeat (4) @(posedge aclk);
      aresetn <= 1'b1;
      reg_rd(ADDR_STATUS, {16'h0, SR_RESET}, RESP_OKAY);
      reg_rd(ADDR_CONTROL, {16'h0, CC_RESET}, RESP_OKAY);
      reg_rd(ADDR_PC, 32'h0, RESP_OKAY);
      // Status writes, then again with priority frozen
      st = SR_RESET;
      for (int n = 0; n < 2; n++) begin
         reg_wr(ADDR_INTCTL, n[0] ? 32'h00008000 : 32'h0, RESP_OKAY);
         for (int i = 0; i < 10; i++) begin
            wv = (i == 0) ? 32'hFFFFFFFF : $random(seed);
            reg_wr(ADDR_STATUS, wv, RESP_OKAY);
            st = exp_status(wv[15:0], st, n[0]);
            reg_rd(ADDR_STATUS, {16'h0, st}, RESP_OKAY);
            chk_word("user irq off", {31'h0, st[7:5] == PRIO_USER_OFF}, {31'h0, user_irq_disabled});
         end
      end
      cc = CC_RESET;
      for (int i = 0; i < 10; i++) begin
         wv = (i == 0) ? 32'hFFFFFFFF : $random(seed);
         reg_wr(ADDR_CONTROL, wv, RESP_OKAY);
         cc = exp_control(wv[15:0], cc);
         reg_rd(ADDR_CONTROL, {16'h0, cc}, RESP_OKAY);
      end
      // Region edges first, then random addresses
      for (int i = 0; i < 16; i++) begin
         wv = $random(seed);
         reg_wr(ADDR_PAGE, {24'h0, wv[7:0]}, RESP_OKAY);
         reg_wr(ADDR_CONTROL, {29'h0, i[0], 2'h0}, RESP_OKAY);
         data_addr <= (i < 8) ? corner[i] : wv[31:16];
         @(posedge aclk);
         chk_word("window hit", {31'h0, i[0] & data_addr[15]}, {31'h0, addr_is_window});
         chk_word("dma hit", {31'h0, data_addr >= 16'h4000 && data_addr < 16'h4800}, {31'h0, addr_is_dma});
         chk_word("program addr", {9'h0, wv[7:0], data_addr[14:0]}, {8'h0, program_addr});
      end
      reg_rd(8'h20, 32'h0, RESP_SLVERR);
      reg_wr(8'h20, 32'h00001234, RESP_SLVERR);
      // Every working register, stack pointer included
      for (int i = 0; i < REG_COUNT; i++) begin
         wv = $random(seed);
         wsave[i] = wv[15:0];
         reg_wr(ADDR_WREG + 8'(4 * i), wv, RESP_OKAY);
      end
      for (int i = 0; i < REG_COUNT; i++)
         reg_rd(ADDR_WREG + 8'(4 * i), {16'h0, wsave[i]}, RESP_OKAY);
      // Back-to-back single-cycle ops step the counter by two each
      instr.valid <= 1'b1;
      repeat (37) begin
         @(posedge aclk);
         fetch_word <= INSTR_WIDTH'($random(seed));
      end
      instr.valid <= 1'b0;
      @(posedge aclk);
      chk_word("pc", 32'h0000004A, {9'h0, pc});
      reg_rd(ADDR_PC, 32'h0000004A, RESP_OKAY);
      // Request above priority 6 is taken and pushes the stack pointer
      reg_wr(ADDR_INTCTL, 32'h0, RESP_OKAY);
      reg_wr(ADDR_STATUS, 32'h000000C0, RESP_OKAY);
      irq_request <= 1'b1;
      irq_level <= 4'h7;
      @(posedge aclk);
      irq_request <= 1'b0;
      @(posedge aclk);
      chk_word("irq taken", 32'h1, {31'h0, irq_taken});
      reg_rd(ADDR_WREG + 8'h3C, {16'h0, wsave[15] + 16'h0002}, RESP_OKAY);
      print_verdict();
   end
endmodule : cpu_core_status_control_bench
`default_nettype wire
